// [inc/dci_defs.svh]
// Offsets, field positions and reset values of the daisy-chain interrupt logic
`ifndef DCI_DEFS_SVH
`define DCI_DEFS_SVH
// Register offsets (4-bit address)
`define DCI_OFS_MASTER 4'h0
`define DCI_OFS_SRC0 4'h1
`define DCI_OFS_SRC4 4'h5
`define DCI_OFS_VEC0 4'h6
`define DCI_OFS_VEC2 4'h8
`define DCI_OFS_CURVEC 4'h9
// Master control field positions
`define DCI_MC_GLOBAL_EN 0
`define DCI_MC_VEC_SUPPRESS 1
`define DCI_MC_BLOCK_LOWER 2
`define DCI_MC_MUX 3
// Source command/status fields
`define DCI_SC_PEND 0
`define DCI_SC_SERVICE 1
`define DCI_SC_ENABLE 2
`define DCI_SC_CMD_HI 6
`define DCI_SC_CMD_LO 4
// Source commands
`define DCI_CMD_NONE 3'h0
`define DCI_CMD_SET_PEND 3'h1
`define DCI_CMD_CLR_PEND 3'h2
`define DCI_CMD_CLR_IUS 3'h3
// Sizes and reset values
`define DCI_NSRC 5
`define DCI_NVEC 3
`define DCI_VEC_RST 8'h00
`define DCI_NO_VEC 8'hFF
// Source index by priority, highest first
`define DCI_SRC_CT3 3'h0
`define DCI_SRC_PA 3'h1
`define DCI_SRC_CT2 3'h2
`define DCI_SRC_PB 3'h3
`define DCI_SRC_CT1 3'h4
`endif

// [inc/dci_pkg.sv]
// Types of the daisy-chain interrupt logic
package dci_pkg;
	// Master control bits
	typedef struct packed {
		logic mux_bus;
		logic block_lower_chain;
		logic vector_suppress;
		logic global_irq_enable;
	} dci_master_t;
	// Per-source flag vectors, index 0 highest priority
	typedef struct packed {
		logic [4:0] pending_flag;
		logic [4:0] under_service_flag;
		logic [4:0] source_mask_enable;
	} dci_flags_t;
	// Acknowledge sequence states
	typedef enum logic [1:0] {
		DCI_IDLE,
		DCI_SETTLE,
		DCI_SERVE
	} dci_state_t;
endpackage : dci_pkg

// [rtl/dci_chain.sv]
// Internal daisy chain across the five sources
`timescale 1ns/10ps
`include "dci_defs.svh"
module dci_chain (
	input wire dci_pkg::dci_flags_t flags,
	input wire logic global_irq_enable,
	input wire logic chain_in,
	input wire logic ack_phase,
	output logic [4:0] req,
	output logic chain_out
);
	// Chain link into each source
	logic [5:0] link;
	assign link[0] = chain_in; // [RL24]
	genvar i;
	generate
		for (i = 0; i < `DCI_NSRC; i = i + 1) begin : g_stage
			// Unmasked: pending, enabled, master on, not in service
			logic unmasked;
			assign unmasked = flags.pending_flag[i] & flags.source_mask_enable[i]
				& global_irq_enable & ~flags.under_service_flag[i]; // [RL7] [RL9] [RL10]
			// Request only with a high chain input
			assign req[i] = unmasked & link[i]; // [RL11]
			// Service, or unmasked pending in an ack, pulls the chain low
			assign link[i+1] = link[i] & ~flags.under_service_flag[i]
				& ~(ack_phase & unmasked); // [RL9] [RL14] [RL24]
		end
	endgenerate
	assign chain_out = link[5]; // [RL1]
endmodule : dci_chain

// [rtl/dci_irq_logic.sv]
// Daisy-chain interrupt logic: flags, chain, acknowledge and vector
// Behaviour
// RL1: fixed priority CT3, PA, CT2, PB, CT1
// RL2: chain input low blocks the request
// RL3: chain output low inhibits lower devices
// RL4: each source keeps pending, service, enable bits
// RL5: source event sets its pending flag
// RL6: software command can set pending flag
// RL7: disabled source still pends, never requests
// RL8: ack sets service flag of winner only
// RL9: service flag masks pending, holds chain low
// RL10: master enable off masks every source
// RL11: request needs all enables and chain high
// RL12: CPU answers request with acknowledge cycle
// RL13: chain settles before the data strobe
// RL14: unmasked pending pulls chain low in ack
// RL15: exactly one source is acknowledged
// RL16: no pending set during acknowledge
// RL17: multiplexed bus updates on address strobe fall
// RL18: separate strobes update only in idle
// RL19: external ack input is clock synchronous
// RL20: service flag cleared only by software write
// RL21: vector driven unless vector suppress set
// RL22: block lower chain forces chain output low
// RL23: blocked events are held, not lost
// RL24: internal chain links sources by priority
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "dci_defs.svh"
module dci_irq_logic (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [4:0] src_event,
	input wire logic chain_enable_in,
	input wire logic irq_ack_cycle_n,
	input wire logic ack_input_n,
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	output logic chain_enable_out,
	output logic irq_request_n,
	output logic [7:0] vec_data,
	output logic vec_oe
);
	// Lowest set index, i.e. highest priority source
	function automatic logic [2:0] top_src(input logic [4:0] v);
		top_src = 3'h7;
		for (int k = `DCI_NSRC - 1; k >= 0; k--) begin
			if (v[k]) begin
				top_src = 3'(k);
			end
		end
	endfunction : top_src

	// Vector register that serves a source; counters share one
	function automatic logic [1:0] vec_sel(input logic [2:0] s);
		case (s)
			`DCI_SRC_PA: vec_sel = 2'h0;
			`DCI_SRC_PB: vec_sel = 2'h1;
			default: vec_sel = 2'h2;
		endcase
	endfunction : vec_sel

	dci_pkg::dci_master_t master; // Master control
	dci_pkg::dci_flags_t flags; // Per-source flags, packed view
	logic [4:0] pending; // Pending flags
	logic [4:0] in_service; // Service flags
	logic [4:0] src_enable; // Source enables
	dci_pkg::dci_state_t state; // Acknowledge sequence
	logic [7:0] vec_reg [`DCI_NVEC]; // Base vectors
	logic [4:0] ev_hold; // Events waiting for an update point
	logic [4:0] req; // Per-source requests
	logic chain_int; // Chain output of the lowest source
	logic [4:0] sync1; // First synchroniser stage
	logic [4:0] sync2; // Second synchroniser stage
	logic astb_prev; // Address strobe, one cycle older
	logic dstb_prev; // Data strobe, one cycle older
	logic cei_s; // Synchronised chain input
	logic ack_s; // Synchronised acknowledge, active high
	logic astb_fall; // Address strobe falling
	logic dstb_fall; // Data strobe falling
	logic upd_ok; // Pending flags may change now
	logic ack_phase; // Acknowledge in progress
	logic [4:0] sw_set; // Software set-pending command
	logic [4:0] sw_clr; // Software clear-pending command
	logic [4:0] sw_clr_ius; // Software clear-service command
	logic [4:0] ack_set; // Service flag set by acknowledge
	logic [2:0] win; // Winning source index
	logic [7:0] next_rdata; // Read mux output

	// One writer per flag vector; the chain sees them as one struct
	assign flags = {pending, in_service, src_enable};

	// Pins are asynchronous: two flops before anything reads them
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1 <= 5'h1F;
			sync2 <= 5'h1F;
		end else begin
			sync1 <= {chain_enable_in, irq_ack_cycle_n, ack_input_n, addr_strobe_n, data_strobe_n};
			sync2 <= sync1;
		end
	end

	// Edge history, taken from the second stage only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			astb_prev <= 1'b1;
			dstb_prev <= 1'b1;
		end else begin
			astb_prev <= sync2[1];
			dstb_prev <= sync2[0];
		end
	end

	assign cei_s = sync2[4];
	// Ack source depends on bus variant; the separate variant
	// expects ack_input_n timed to this clock
	assign ack_s = master.mux_bus ? ~sync2[3] : ~sync2[2]; // [RL19]
	assign astb_fall = astb_prev & ~sync2[1];
	assign dstb_fall = dstb_prev & ~sync2[0];
	assign ack_phase = (state != dci_pkg::DCI_IDLE);
	// Update points: strobe fall outside ack, or idle state
	assign upd_ok = master.mux_bus ? (astb_fall & ~ack_phase) // [RL17] [RL16]
		: (state == dci_pkg::DCI_IDLE); // [RL18] [RL16]

	// Software commands decoded per source
	genvar g;
	generate
		for (g = 0; g < `DCI_NSRC; g = g + 1) begin : g_cmd
			logic hit;
			assign hit = reg_wr && (reg_addr == `DCI_OFS_SRC0 + 4'(g));
			assign sw_set[g] = hit && (reg_wdata[`DCI_SC_CMD_HI:`DCI_SC_CMD_LO] == `DCI_CMD_SET_PEND);
			assign sw_clr[g] = hit && (reg_wdata[`DCI_SC_CMD_HI:`DCI_SC_CMD_LO] == `DCI_CMD_CLR_PEND);
			assign sw_clr_ius[g] = hit && (reg_wdata[`DCI_SC_CMD_HI:`DCI_SC_CMD_LO] == `DCI_CMD_CLR_IUS);
		end
	endgenerate

	// Chain through the five sources
	dci_chain u_chain (
		.flags(flags),
		.global_irq_enable(master.global_irq_enable),
		.chain_in(cei_s),
		.ack_phase(ack_phase),
		.req(req),
		.chain_out(chain_int)
	);

	// After settling only the winner still requests
	assign win = top_src(req); // [RL15]
	assign ack_set = (state == dci_pkg::DCI_SETTLE && dstb_fall) ? req : 5'h00; // [RL8] [RL13]

	// Acknowledge sequence: settle until the strobe, then serve
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= dci_pkg::DCI_IDLE;
		end else begin
			case (state)
				dci_pkg::DCI_IDLE: begin
					if (ack_s) begin
						state <= dci_pkg::DCI_SETTLE; // [RL12]
					end
				end
				dci_pkg::DCI_SETTLE: begin
					// Chain resolves here; strobe closes it
					if (!ack_s) begin
						state <= dci_pkg::DCI_IDLE;
					end else if (dstb_fall) begin
						state <= dci_pkg::DCI_SERVE; // [RL13]
					end
				end
				dci_pkg::DCI_SERVE: begin
					if (!ack_s) begin
						state <= dci_pkg::DCI_IDLE;
					end
				end
				default: begin
					state <= dci_pkg::DCI_IDLE;
				end
			endcase
		end
	end

	// Events held until an update point; the drain clears the hold, a new event then goes straight to pending
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ev_hold <= 5'h00;
		end else if (upd_ok) begin
			ev_hold <= 5'h00; // [RL23]
		end else begin
			ev_hold <= ev_hold | src_event | sw_set; // [RL23] [RL6]
		end
	end

	// Pending flags; a set in the same cycle wins over a clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pending <= 5'h00;
		end else if (upd_ok) begin
			pending <= (pending & ~sw_clr) | ev_hold | src_event | sw_set; // [RL5] [RL6] [RL7]
		end else begin
			// Clears act at once; sets wait in the hold register
			pending <= pending & ~sw_clr;
		end
	end

	// Service flags: set by acknowledge, cleared only by software
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			in_service <= 5'h00;
		end else begin
			in_service <= (in_service & ~sw_clr_ius) | ack_set; // [RL8] [RL20]
		end
	end

	// Enables, master control and base vectors written by software
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			src_enable <= 5'h00;
			master <= '0;
			for (int k = 0; k < `DCI_NVEC; k++) begin
				vec_reg[k] <= `DCI_VEC_RST;
			end
		end else if (reg_wr) begin
			if (reg_addr == `DCI_OFS_MASTER) begin
				master.global_irq_enable <= reg_wdata[`DCI_MC_GLOBAL_EN];
				master.vector_suppress <= reg_wdata[`DCI_MC_VEC_SUPPRESS];
				master.block_lower_chain <= reg_wdata[`DCI_MC_BLOCK_LOWER];
				master.mux_bus <= reg_wdata[`DCI_MC_MUX];
			end
			for (int k = 0; k < `DCI_NSRC; k++) begin
				if (reg_addr == `DCI_OFS_SRC0 + 4'(k)) begin
					src_enable[k] <= reg_wdata[`DCI_SC_ENABLE]; // [RL4]
				end
			end
			for (int k = 0; k < `DCI_NVEC; k++) begin
				if (reg_addr == `DCI_OFS_VEC0 + 4'(k)) begin
					vec_reg[k] <= reg_wdata;
				end
			end
		end
	end

	// Request and chain pins, registered
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_request_n <= 1'b1;
			chain_enable_out <= 1'b1;
		end else begin
			irq_request_n <= ~(|req); // [RL2] [RL11]
			chain_enable_out <= chain_int & ~master.block_lower_chain; // [RL3] [RL22]
		end
	end

	// Vector drive: from the strobe fall until the strobe or ack ends
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			vec_oe <= 1'b0;
			vec_data <= 8'h00;
		end else if (ack_set != 5'h00) begin
			// Service flag is set whether or not the vector is driven
			vec_oe <= ~master.vector_suppress; // [RL21]
			vec_data <= vec_reg[vec_sel(win)]; // [RL21]
		end else if (!ack_s || sync2[0]) begin
			vec_oe <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr == `DCI_OFS_MASTER) begin
			next_rdata = {4'h0, master};
		end else if (reg_addr >= `DCI_OFS_SRC0 && reg_addr <= `DCI_OFS_SRC4) begin
			next_rdata = {5'h00, flags.source_mask_enable[3'(reg_addr - `DCI_OFS_SRC0)],
				flags.under_service_flag[3'(reg_addr - `DCI_OFS_SRC0)],
				flags.pending_flag[3'(reg_addr - `DCI_OFS_SRC0)]};
		end else if (reg_addr >= `DCI_OFS_VEC0 && reg_addr <= `DCI_OFS_VEC2) begin
			next_rdata = vec_reg[2'(reg_addr - `DCI_OFS_VEC0)];
		end else if (reg_addr == `DCI_OFS_CURVEC) begin
			// Polled view: vector of the top unmasked request
			next_rdata = (req == 5'h00) ? `DCI_NO_VEC : vec_reg[vec_sel(win)];
		end
	end

	// Read data stand for one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Checks on the logic above
	a_chain_in_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL2]
		!cei_s |=> irq_request_n) else $error("request with chain input low");
	a_lower_block: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL22]
		master.block_lower_chain |=> !chain_enable_out) else $error("chain out high while blocked");
	a_service_chain: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL9]
		(flags.under_service_flag != 5'h00) |=> !chain_enable_out) else $error("chain out high in service");
	a_master_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL10]
		!master.global_irq_enable |=> irq_request_n) else $error("request with master off");
	a_masked_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL7]
		((flags.pending_flag & flags.source_mask_enable & ~flags.under_service_flag) == 5'h00)
		|=> irq_request_n) else $error("request without unmasked pending");
	a_no_pend_ack: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL16]
		ack_phase |=> ((flags.pending_flag & ~$past(flags.pending_flag)) == 5'h00))
		else $error("pending set during acknowledge");
	a_one_winner: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL15]
		(state == dci_pkg::DCI_SETTLE) |-> $onehot0(req)) else $error("more than one winner");
	a_ius_winner: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL8]
		(state == dci_pkg::DCI_SETTLE && dstb_fall && !reg_wr)
		|=> (flags.under_service_flag == ($past(flags.under_service_flag) | $past(req))))
		else $error("service flag not set for winner");
	a_ius_sw_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL20]
		(($past(flags.under_service_flag) & ~flags.under_service_flag) == 5'h00) || $past(reg_wr))
		else $error("service flag cleared without write");
	a_vector_drive: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL21]
		(ack_set != 5'h00) |=> (vec_oe == !$past(master.vector_suppress)))
		else $error("vector drive wrong at strobe");

	// Bus variant update points and held events
	a_mux_update: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL17]
		(master.mux_bus && !astb_fall) |=> ((flags.pending_flag & ~$past(flags.pending_flag)) == 5'h00))
		else $error("pending set without address strobe fall");
	a_idle_update: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL18]
		(!master.mux_bus && state != dci_pkg::DCI_IDLE)
		|=> ((flags.pending_flag & ~$past(flags.pending_flag)) == 5'h00))
		else $error("pending set outside idle");
	a_held_event: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL23]
		upd_ok |=> ((flags.pending_flag & $past(ev_hold)) == $past(ev_hold)))
		else $error("held event lost at update point");

	// Chain, request and vector values
	a_ack_chain: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL14]
		(ack_phase && req != 5'h00) |=> !chain_enable_out) else $error("chain out high with request in ack");
	a_request_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL11]
		(req != 5'h00) |=> !irq_request_n) else $error("no request with unmasked pending");
	a_vector_value: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RL21]
		(ack_set != 5'h00 && !reg_wr) |=> (vec_data == vec_reg[vec_sel($past(win))]))
		else $error("vector data wrong at strobe");
endmodule : dci_irq_logic

// [test/dci_host_model.sv]
// Host processor model running acknowledge cycles
`timescale 1ns/10ps
module dci_host_model (
	input wire logic sys_clk,
	input wire logic start,
	input wire logic [3:0] settle,
	output logic ack_n,
	output logic strobe_n,
	output logic busy
);
	// One acknowledge cycle per start pulse, pins moved just after the edge
	initial begin
		ack_n = 1'b1;
		strobe_n = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (start) begin
				busy <= 1'b1;
				ack_n <= 1'b0;
				// Strobe held back until the chain has settled
				repeat (settle) @(posedge sys_clk);
				strobe_n <= 1'b0;
				repeat (6) @(posedge sys_clk);
				strobe_n <= 1'b1;
				ack_n <= 1'b1;
				repeat (6) @(posedge sys_clk);
				busy <= 1'b0;
			end
		end
	end
endmodule : dci_host_model

// [test/tb_top.sv]
// Self-checking bench for the daisy-chain interrupt logic
`timescale 1ns/10ps
`include "dci_defs.svh"
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [4:0] src_event = 5'h00;
	logic chain_in = 1'b1;
	logic astb_n = 1'b1;
	logic start = 1'b0;
	logic [3:0] settle = 4'h6;
	logic [7:0] reg_rdata, vec_data, vec_seen;
	logic ack_n, strobe_n, busy, chain_out, irq_n, vec_oe, oe_seen, ceo_min;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	logic rd_d = 1'b0;
	logic [7:0] vec [3]; // Images of the three vector registers
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	initial forever #25 sys_clk = ~sys_clk;
	dci_irq_logic dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
		.chain_enable_in(chain_in), .irq_ack_cycle_n(ack_n), .ack_input_n(ack_n), .addr_strobe_n(astb_n),
		.data_strobe_n(strobe_n), .chain_enable_out(chain_out), .irq_request_n(irq_n), .vec_data(vec_data),
		.vec_oe(vec_oe));
	dci_host_model host (.sys_clk(sys_clk), .start(start), .settle(settle), .ack_n(ack_n),
		.strobe_n(strobe_n), .busy(busy));
	// Single comparison point, unknowns never match
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	// Register write, one cycle strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Register read, expectation queued for the monitor
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd
	// Pins pass two synchroniser flops, so let them settle first
	task automatic pins(input logic irq_e, input logic ceo_e);
		repeat (5) @(posedge sys_clk);
		#1;
		check({7'h00, irq_n}, {7'h00, irq_e});
		check({7'h00, chain_out}, {7'h00, ceo_e});
	endtask : pins
	task automatic ev(input logic [4:0] b);
		@(posedge sys_clk);
		src_event <= b;
		@(posedge sys_clk);
		src_event <= 5'h00;
	endtask : ev
	// Runs one acknowledge cycle, an event pulse lands in mid-cycle
	task automatic ack(input logic [4:0] mid);
		oe_seen = 1'b0;
		ceo_min = 1'b1;
		@(posedge sys_clk);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge sys_clk);
			src_event <= (i == 6) ? mid : 5'h00;
			#1;
			// Before the strobe only the ack pull-down can lower the chain
			if (strobe_n) begin
				ceo_min &= chain_out;
			end
			if (vec_oe === 1'b1) begin
				oe_seen = 1'b1;
				vec_seen = vec_data;
			end
		end
	endtask : ack
	// Read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_d) begin
			check(reg_rdata, exp_q.pop_front());
		end
		rd_d <= reg_rd;
	end
	// Hang guard, far above the expected run length
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h477cb621));
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) rd(a[3:0], (a == 9) ? `DCI_NO_VEC : `DCI_VEC_RST);
		for (int i = 0; i < 3; i++) begin
			vec[i] = 8'($urandom());
			wr(4'(`DCI_OFS_VEC0 + i), vec[i]);
			rd(4'(`DCI_OFS_VEC0 + i), vec[i]);
		end
		for (int s = 0; s < 5; s++) wr(4'(`DCI_OFS_SRC0 + s), 8'h04);
		wr(4'h4, 8'h00);
		wr(`DCI_OFS_MASTER, 8'h01);
		ev(5'h08);
		rd(4'h4, 8'h01);
		pins(1'b1, 1'b1);
		ev(5'h10);
		rd(4'h5, 8'h05);
		pins(1'b0, 1'b1);
		rd(`DCI_OFS_CURVEC, vec[2]);
		chain_in <= 1'b0;
		pins(1'b1, 1'b0);
		chain_in <= 1'b1;
		wr(`DCI_OFS_MASTER, 8'h00);
		pins(1'b1, 1'b1);
		wr(`DCI_OFS_MASTER, 8'h01);
		// Software command sets the port A flag
		wr(4'h2, 8'h14);
		rd(4'h2, 8'h05);
		rd(`DCI_OFS_CURVEC, vec[0]);
		ack(5'h04);
		check({7'h00, oe_seen}, 8'h01);
		check(vec_seen, vec[0]);
		check({7'h00, ceo_min}, 8'h00);
		rd(4'h2, 8'h07);
		rd(4'h5, 8'h05);
		rd(4'h3, 8'h05);
		pins(1'b1, 1'b0);
		repeat (20) @(posedge sys_clk);
		rd(4'h2, 8'h07);
		wr(4'h2, 8'h34);
		rd(4'h2, 8'h05);
		pins(1'b0, 1'b1);
		wr(`DCI_OFS_MASTER, 8'h05);
		pins(1'b0, 1'b0);
		// Clear port A, then acknowledge with the vector held back
		wr(4'h2, 8'h24);
		wr(`DCI_OFS_MASTER, 8'h03);
		settle <= 4'h3;
		ack(5'h00);
		check({7'h00, oe_seen}, 8'h00);
		rd(4'h3, 8'h07);
		rd(4'h5, 8'h05);
		// Multiplexed bus: an event waits for the address strobe fall
		wr(`DCI_OFS_MASTER, 8'h09);
		ev(5'h01);
		rd(4'h1, 8'h04);
		@(posedge sys_clk);
		astb_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		astb_n <= 1'b1;
		rd(4'h1, 8'h05);
		rd(`DCI_OFS_CURVEC, vec[2]);
		pins(1'b0, 1'b0);
		repeat (3) @(posedge sys_clk);
		give_verdict();
	end
endmodule : tb_top
